/* logic/cmd_cfg.svh */
// Command codes, frame layout, error codes and host register map
`ifndef CMD_CFG_SVH
`define CMD_CFG_SVH
`define CMD_GET_DETECTED 8'h46
`define CMD_GET_FLAGS 8'h47
`define CMD_SET_EXCHANGE 8'h48
`define CMD_GET_MISMATCH 8'h57
`define TOGGLE_BIT 7
`define ZERO_BIT 6
`define SEGMENT_BIT 0
`define REQ_LEN_SHORT 2'h2
`define REQ_LEN_LONG 2'h3
`define RSP_LEN_BITMAP 4'hA
`define RSP_LEN_FLAGS 4'h5
`define RSP_LEN_BARE 4'h2
`define RSP_BYTES 10
`define ERR_OK 7'h00
`define ERR_BAD_CMD 7'h01
`define ERR_BAD_FORMAT 7'h02
`define EXCHANGE_RESET 2'h0
`define REG_CTRL 12'h000
`define REG_STATUS 12'h004
`define REG_RSP0 12'h008
`define REG_RSP1 12'h00C
`define REG_RSP2 12'h010
`define CTRL_SEG_BIT 8
`define CTRL_PAYLOAD_BIT 9
`define STAT_BUSY_BIT 0
`define STAT_DONE_BIT 1
`define STAT_TOGGLE_BIT 2
`endif

/* logic/cmd_pkg.sv */
// Types shared by both ends of the command link
package cmd_pkg;
	typedef logic [7:0] byte_t;
	typedef logic [63:0] node_map_t;
	typedef enum logic [1:0] {DEV_RX, DEV_BUILD, DEV_TX} dev_state_t;
	typedef enum logic [1:0] {HOST_IDLE, HOST_SEND, HOST_RECV} host_state_t;
endpackage

/* logic/cmd_link_if.sv */
// Byte-stream command link between host controller and gateway
`timescale 1ns/1ps
interface cmd_link_if (
	input wire logic pclk,
	input wire logic presetn
);
	import cmd_pkg::*;
	logic req_valid;
	logic req_ready;
	byte_t req_data;
	logic req_last;
	logic rsp_valid;
	logic rsp_ready;
	byte_t rsp_data;
	logic rsp_last;
	modport device (input pclk, presetn, req_valid, req_data, req_last, rsp_ready,
		output req_ready, rsp_valid, rsp_data, rsp_last);
	modport host (input pclk, presetn, req_ready, rsp_valid, rsp_data, rsp_last,
		output req_valid, req_data, req_last, rsp_ready);
endinterface

/* logic/gateway_cmd_handler.sv */
// Gateway end: decodes node-list and flag commands and answers them
//
`timescale 1ns/1ps
`include "cmd_cfg.svh"
module gateway_cmd_handler (
	input wire logic pclk,
	input wire logic presetn,
	cmd_link_if.device link,
	input wire cmd_pkg::node_map_t detected_list [2],
	input wire cmd_pkg::node_map_t projected_list [2],
	input wire cmd_pkg::node_map_t periph_fault_list [2],
	input wire logic [1:0] low_supply,
	input wire logic configuration_mode,
	input wire logic normal_running,
	input wire logic offline_mode,
	input wire logic offline_requested,
	input wire logic auto_addressing_allowed,
	output logic [1:0] exchange_enable_flag,
	output logic [1:0] id_read_only
);
	import cmd_pkg::*;

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	// Address 0 of both halves has no assignable node
	function automatic node_map_t usable(input node_map_t m);
		usable = m & ~64'h0000_0001_0000_0001;
	endfunction

	function automatic logic exactly_one(input node_map_t m);
		exactly_one = (m != 64'h0) && ((m & (m - 64'h1)) == 64'h0);
	endfunction

	// ----------------------------------------
	// State
	// ----------------------------------------
	dev_state_t state_reg;
	byte_t rx_buf [3];
	logic [1:0] rx_cnt_reg;
	byte_t tx_buf [`RSP_BYTES];
	logic [3:0] tx_cnt_reg;
	logic offline_seen_reg;

	// ----------------------------------------
	// Response build
	// ----------------------------------------
	byte_t code;
	logic seg;
	node_map_t lds;
	node_map_t lps;
	node_map_t missing;
	logic [6:0] err;
	logic [3:0] rsp_len;
	logic auto_addressing_possible_flag;
	logic auto_address_ready_flag;
	node_map_t detected_use;
	node_map_t mismatch_map;
	byte_t payload [8];

	always_comb begin
		code = rx_buf[0];
		seg = rx_buf[1][`SEGMENT_BIT];
		lds = detected_list[seg];
		lps = projected_list[seg];
		missing = usable(lps & ~lds);
		detected_use = usable(lds);
		mismatch_map = usable(lps ^ lds);
		auto_address_ready_flag = exactly_one(missing);
		auto_addressing_possible_flag = auto_address_ready_flag && auto_addressing_allowed
			&& !configuration_mode;
		err = `ERR_OK;
		rsp_len = `RSP_LEN_BARE;
		for (int i = 0; i < 8; i++) begin
			payload[i] = 8'h00;
		end
		unique case (code)
			`CMD_GET_DETECTED: begin
				rsp_len = `RSP_LEN_BITMAP;
				for (int i = 0; i < 8; i++) begin
					payload[i] = detected_use[8*i +: 8];
				end
			end
			`CMD_GET_FLAGS: begin
				rsp_len = `RSP_LEN_FLAGS;
				payload[0] = {7'h00, ~|usable(periph_fault_list[seg] & lds)};
				payload[1] = {offline_mode,
					low_supply[seg],
					normal_running,
					configuration_mode,
					auto_address_ready_flag, auto_addressing_possible_flag,
					lds[0],
					usable(lps) == usable(lds)};
				payload[2] = {5'h00, auto_addressing_allowed,
					offline_requested | offline_mode,
					exchange_enable_flag[seg]};
			end
			`CMD_SET_EXCHANGE: begin
				if (rx_cnt_reg != `REQ_LEN_LONG) begin
					err = `ERR_BAD_FORMAT;
				end
			end
			`CMD_GET_MISMATCH: begin
				rsp_len = `RSP_LEN_BITMAP;
				for (int i = 0; i < 8; i++) begin
					payload[i] = mismatch_map[8*i +: 8];
				end
			end
			default: begin
				err = `ERR_BAD_CMD;
			end
		endcase
		if (rx_cnt_reg < `REQ_LEN_SHORT || rx_buf[1][`ZERO_BIT]) begin
			err = `ERR_BAD_FORMAT;
		end
		if (err != `ERR_OK) begin
			rsp_len = `RSP_LEN_BARE;
		end
	end

	// ----------------------------------------
	// Sequencer
	// ----------------------------------------
	assign link.req_ready = (state_reg == DEV_RX);
	assign link.rsp_valid = (state_reg == DEV_TX);
	assign link.rsp_data = tx_buf[0];
	assign link.rsp_last = (tx_cnt_reg == 4'h1);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_reg <= DEV_RX;
		end else begin
			unique case (state_reg)
				DEV_RX: if (link.req_valid && link.req_last) state_reg <= DEV_BUILD;
				DEV_BUILD: state_reg <= DEV_TX;
				DEV_TX: if (link.rsp_ready && tx_cnt_reg == 4'h1) state_reg <= DEV_RX;
			endcase
		end
	end

	// Extra request bytes beyond three are dropped, counter saturates
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rx_cnt_reg <= 2'h0;
			for (int i = 0; i < 3; i++) rx_buf[i] <= 8'h00;
		end else if (state_reg == DEV_TX && link.rsp_ready && tx_cnt_reg == 4'h1) begin
			rx_cnt_reg <= 2'h0;
		end else if (state_reg == DEV_RX && link.req_valid) begin
			if (rx_cnt_reg != `REQ_LEN_LONG) begin
				rx_buf[rx_cnt_reg] <= link.req_data;
				rx_cnt_reg <= rx_cnt_reg + 2'h1;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tx_cnt_reg <= 4'h0;
			for (int i = 0; i < `RSP_BYTES; i++) tx_buf[i] <= 8'h00;
		end else if (state_reg == DEV_BUILD) begin
			tx_cnt_reg <= rsp_len;
			tx_buf[0] <= code;
			tx_buf[1] <= {rx_buf[1][`TOGGLE_BIT], err};
			for (int i = 0; i < 8; i++) tx_buf[i + 2] <= payload[i];
		end else if (state_reg == DEV_TX && link.rsp_ready) begin
			tx_cnt_reg <= tx_cnt_reg - 4'h1;
			for (int i = 0; i < `RSP_BYTES - 1; i++) tx_buf[i] <= tx_buf[i + 1];
			tx_buf[`RSP_BYTES - 1] <= 8'h00;
		end
	end

	// ----------------------------------------
	// Exchange enable
	// ----------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			offline_seen_reg <= 1'b0;
		end else begin
			offline_seen_reg <= offline_mode;
		end
	end

	// Offline entry wins over a clearing command in the same cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			exchange_enable_flag <= `EXCHANGE_RESET;
		end else if (offline_mode && !offline_seen_reg) begin
			exchange_enable_flag <= 2'h3;
		end else if (state_reg == DEV_BUILD && code == `CMD_SET_EXCHANGE && err == `ERR_OK) begin
			exchange_enable_flag[seg] <= rx_buf[2][0];
		end
	end

	assign id_read_only = ~exchange_enable_flag;
endmodule

/* logic/host_cmd_master.sv */
// Host end: APB registers drive command frames and collect responses
`timescale 1ns/1ps
`include "cmd_cfg.svh"
module host_cmd_master (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	cmd_link_if.host link
);
	import cmd_pkg::*;

	// ----------------------------------------
	// Registers
	// ----------------------------------------
	host_state_t state_reg;
	byte_t code_reg;
	logic seg_reg;
	logic payload_reg;
	logic toggle_reg;
	logic done_reg;
	byte_t req_buf [3];
	logic [1:0] req_cnt_reg;
	byte_t rsp_buf [`RSP_BYTES];
	logic [3:0] rsp_idx_reg;

	logic access;
	logic wr_ctrl;
	logic start;
	logic mapped;

	assign access = psel && penable;
	assign wr_ctrl = access && pwrite && paddr == `REG_CTRL;
	// Control register writes while a command is in flight are dropped
	assign start = wr_ctrl && state_reg == HOST_IDLE;
	assign mapped = paddr == `REG_CTRL || paddr == `REG_STATUS || paddr == `REG_RSP0
		|| paddr == `REG_RSP1 || paddr == `REG_RSP2;
	assign pready = 1'b1;
	assign pslverr = access && !mapped;

	always_comb begin
		unique case (paddr)
			`REG_CTRL: prdata = {22'h0, payload_reg, seg_reg, code_reg};
			`REG_STATUS: prdata = {29'h0, toggle_reg, done_reg, state_reg != HOST_IDLE};
			`REG_RSP0: prdata = {rsp_buf[3], rsp_buf[2], rsp_buf[1], rsp_buf[0]};
			`REG_RSP1: prdata = {rsp_buf[7], rsp_buf[6], rsp_buf[5], rsp_buf[4]};
			`REG_RSP2: prdata = {16'h0, rsp_buf[9], rsp_buf[8]};
			default: prdata = 32'h0;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			code_reg <= 8'h00;
			seg_reg <= 1'b0;
			payload_reg <= 1'b0;
		end else if (start) begin
			code_reg <= pwdata[7:0];
			seg_reg <= pwdata[`CTRL_SEG_BIT];
			payload_reg <= pwdata[`CTRL_PAYLOAD_BIT];
		end
	end

	// Completion wins over a software clear in the same cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			done_reg <= 1'b0;
		end else if (state_reg == HOST_RECV && link.rsp_valid && link.rsp_last) begin
			done_reg <= 1'b1;
		end else if (access && pwrite && paddr == `REG_STATUS && pwdata[`STAT_DONE_BIT]) begin
			done_reg <= 1'b0;
		end
	end

	// ----------------------------------------
	// Frame sequencer
	// ----------------------------------------
	assign link.req_valid = (state_reg == HOST_SEND);
	assign link.req_data = req_buf[0];
	assign link.req_last = (req_cnt_reg == 2'h1);
	assign link.rsp_ready = (state_reg == HOST_RECV);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_reg <= HOST_IDLE;
		end else begin
			unique case (state_reg)
				HOST_IDLE: if (start) state_reg <= HOST_SEND;
				HOST_SEND: if (link.req_ready && req_cnt_reg == 2'h1) state_reg <= HOST_RECV;
				HOST_RECV: if (link.rsp_valid && link.rsp_last) state_reg <= HOST_IDLE;
			endcase
		end
	end

	// Toggle flips per command so the gateway can tell repeats apart
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			toggle_reg <= 1'b0;
			req_cnt_reg <= 2'h0;
			for (int i = 0; i < 3; i++) req_buf[i] <= 8'h00;
		end else if (start) begin
			toggle_reg <= ~toggle_reg;
			req_buf[0] <= pwdata[7:0];
			req_buf[1] <= {~toggle_reg, 6'h00, pwdata[`CTRL_SEG_BIT]};
			req_buf[2] <= {7'h00, pwdata[`CTRL_PAYLOAD_BIT]};
			req_cnt_reg <= (pwdata[7:0] == `CMD_SET_EXCHANGE) ? `REQ_LEN_LONG : `REQ_LEN_SHORT;
		end else if (state_reg == HOST_SEND && link.req_ready) begin
			req_cnt_reg <= req_cnt_reg - 2'h1;
			req_buf[0] <= req_buf[1];
			req_buf[1] <= req_buf[2];
			req_buf[2] <= 8'h00;
		end
	end

	// Bytes past the tenth are dropped; unfilled bytes read zero
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rsp_idx_reg <= 4'h0;
			for (int i = 0; i < `RSP_BYTES; i++) rsp_buf[i] <= 8'h00;
		end else if (start) begin
			rsp_idx_reg <= 4'h0;
			for (int i = 0; i < `RSP_BYTES; i++) rsp_buf[i] <= 8'h00;
		end else if (state_reg == HOST_RECV && link.rsp_valid && rsp_idx_reg < 4'hA) begin
			rsp_buf[rsp_idx_reg] <= link.rsp_data;
			rsp_idx_reg <= rsp_idx_reg + 4'h1;
		end
	end
endmodule

/* verif/cmd_link_props.sv */
// Checker for the byte link between host and gateway ends
`timescale 1ns/1ps
module cmd_link_props (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic req_valid,
	input wire logic req_ready,
	input wire cmd_pkg::byte_t req_data,
	input wire logic req_last,
	input wire logic rsp_valid,
	input wire logic rsp_ready,
	input wire cmd_pkg::byte_t rsp_data,
	input wire logic rsp_last
);
	import cmd_pkg::*;
	logic [1:0] req_idx_reg;
	logic [3:0] rsp_idx_reg;
	byte_t code_reg;
	logic tog_reg;
	wire req_go = req_valid && req_ready;
	wire rsp_go = rsp_valid && rsp_ready;
	wire bitmap = code_reg == 8'h46 || code_reg == 8'h57;
	// ----
	// Frame position trackers
	// ----
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) req_idx_reg <= 2'h0;
		else if (req_go) req_idx_reg <= req_last ? 2'h0 : req_idx_reg + 2'h1;
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) rsp_idx_reg <= 4'h0;
		else if (rsp_go) rsp_idx_reg <= rsp_last ? 4'h0 : rsp_idx_reg + 4'h1;
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) code_reg <= 8'h00;
		else if (req_go && req_idx_reg == 2'h0) code_reg <= req_data;
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) tog_reg <= 1'b0;
		else if (req_go && req_idx_reg == 2'h1) tog_reg <= req_data[7];
	end
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	a_req_held: assert property (req_valid && !req_ready |=> req_valid && $stable(req_data))
		else $error("request byte dropped");
	a_rsp_held: assert property (rsp_valid && !rsp_ready |=> rsp_valid && $stable(rsp_data))
		else $error("response byte dropped");
	a_echo_code: assert property (rsp_valid && rsp_idx_reg == 4'h0 |-> rsp_data == code_reg)
		else $error("code not echoed");
	a_echo_toggle: assert property (rsp_valid && rsp_idx_reg == 4'h1 |-> rsp_data[7] == tog_reg)
		else $error("toggle not echoed");
	a_answer_time: assert property (req_go && req_last |=> !req_ready ##1 rsp_valid)
		else $error("late response");
	a_exch_len: assert property (rsp_valid && code_reg == 8'h48 && rsp_idx_reg == 4'h1 |-> rsp_last)
		else $error("exchange reply length");
	a_flags_len: assert property (rsp_valid && rsp_last && code_reg == 8'h47 |-> rsp_idx_reg == 4'h4)
		else $error("flags reply length");
	a_map_len: assert property (rsp_valid && rsp_last && bitmap |-> rsp_idx_reg == 4'h9)
		else $error("bitmap reply length");
	a_spare_zero: assert property (rsp_valid && code_reg == 8'h47 && rsp_idx_reg == 4'h2 |-> rsp_data[7:1] == 7'h00)
		else $error("spare flag bits set");
	a_map_spare: assert property (rsp_valid && bitmap && (rsp_idx_reg == 4'h2 || rsp_idx_reg == 4'h6) |-> !rsp_data[0])
		else $error("spare bitmap bit set");
endmodule

/* verif/tb_node_list_flag_command_handler.sv */
// Testbench joining the host and gateway ends of the command link
`timescale 1ns/1ps
module tb_node_list_flag_command_handler;
	import cmd_pkg::*;
	localparam node_map_t usable = 64'hFFFF_FFFE_FFFF_FFFE;
	logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [11:0] paddr = '0;
	logic [31:0] pwdata = '0, prdata;
	logic pready, pslverr, slverr, tog = 1'b0;
	node_map_t detected_list [2] = '{'0, '0};
	node_map_t projected_list [2] = '{'0, '0};
	node_map_t periph_fault_list [2] = '{'0, '0};
	logic [1:0] low_supply = '0, exchange_enable_flag, id_read_only;
	logic configuration_mode = 1'b0, normal_running = 1'b0, offline_mode = 1'b0;
	logic offline_requested = 1'b0, auto_addressing_allowed = 1'b0;
	logic [95:0] r;
	int failures = 0, total_checks = 0;
	cmd_link_if link (.pclk, .presetn);
	gateway_cmd_handler gateway_cmd_handler_i (.pclk, .presetn, .link(link), .detected_list, .projected_list,
		.periph_fault_list, .low_supply, .configuration_mode, .normal_running, .offline_mode, .offline_requested,
		.auto_addressing_allowed, .exchange_enable_flag, .id_read_only);
	host_cmd_master host_cmd_master_i (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
		.pready, .pslverr, .link(link));
	cmd_link_props cmd_link_props_i (.pclk, .presetn, .req_valid(link.req_valid), .req_ready(link.req_ready),
		.req_data(link.req_data), .req_last(link.req_last), .rsp_valid(link.rsp_valid),
		.rsp_ready(link.rsp_ready), .rsp_data(link.rsp_data), .rsp_last(link.rsp_last));
	initial forever #25 pclk = ~pclk;
	// ----
	// Shared tasks
	// ----
	task automatic check(input logic [79:0] seen, input logic [79:0] exp);
		total_checks++;
		if (seen !== exp) begin
			failures++;
			$display("unexpected at %0t: saw %h wanted %h", $time, seen, exp);
		end
	endtask
	task automatic close_out;
		$display("checks %0d failures %0d", total_checks, failures);
		if (failures == 0 && total_checks > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] q);
		int n;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (pready !== 1'b1) begin
			failures++;
			close_out;
		end
		q = prdata;
		slverr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	// Toggle starts at one and flips on every command sent
	task automatic run(input byte_t code, input logic seg, input logic pay, input logic [6:0] err);
		logic [31:0] q;
		int n;
		tog = ~tog;
		apb(1'b1, 12'h000, {22'h0, pay, seg, code}, q);
		n = 0;
		do begin
			apb(1'b0, 12'h004, '0, q);
			n++;
		end while (q[1] !== 1'b1 && n < 40);
		if (q[1] !== 1'b1) begin
			failures++;
			close_out;
		end
		check(q[2:1], {tog, 1'b1});
		apb(1'b1, 12'h004, 32'h0000_0002, q);
		for (int i = 0; i < 3; i++) begin
			apb(1'b0, 12'(8 + 4 * i), '0, q);
			r[32*i+:32] = q;
		end
		check(r[15:0], {tog, err, code});
	endtask
	// ----
	// Scenarios
	// ----
	task automatic t_detected;
		detected_list[1] <= 64'hA5C3_0F01_8001_FFFF;
		run(8'h46, 1'b1, 1'b0, 7'h00);
		check(r[95:16], {16'h0, 64'hA5C3_0F00_8001_FFFE});
		$display("detected list done");
	endtask
	task automatic t_flags;
		detected_list[0] <= 64'h41;
		projected_list[0] <= 64'h60;
		periph_fault_list[0] <= 64'h20;
		low_supply <= 2'b01;
		normal_running <= 1'b1;
		offline_requested <= 1'b1;
		auto_addressing_allowed <= 1'b1;
		run(8'h47, 1'b0, 1'b0, 7'h00);
		check(r[95:16], {56'h0, 8'h06, 8'h6E, 8'h01});
		configuration_mode <= 1'b1;
		periph_fault_list[0] <= 64'h40;
		projected_list[0] <= 64'h41;
		low_supply <= 2'b10;
		normal_running <= 1'b0;
		offline_requested <= 1'b0;
		auto_addressing_allowed <= 1'b0;
		run(8'h47, 1'b0, 1'b0, 7'h00);
		check(r[95:16], {56'h0, 8'h00, 8'h13, 8'h00});
		$display("flags done");
	endtask
	task automatic t_exchange;
		run(8'h48, 1'b1, 1'b1, 7'h00);
		check(r[95:16], '0);
		check({exchange_enable_flag, id_read_only}, 4'b1001);
		run(8'h47, 1'b1, 1'b0, 7'h00);
		check(r[32], 1'b1);
		run(8'h48, 1'b1, 1'b0, 7'h00);
		check({exchange_enable_flag, id_read_only}, 4'b0011);
		$display("exchange done");
	endtask
	task automatic t_offline;
		offline_mode <= 1'b1;
		repeat (3) @(posedge pclk);
		check(exchange_enable_flag, 2'b11);
		run(8'h47, 1'b0, 1'b0, 7'h00);
		check({r[31], r[33]}, 2'b11);
		offline_mode <= 1'b0;
		$display("offline done");
	endtask
	task automatic t_other;
		logic [31:0] q;
		projected_list[0] <= 64'h8000_0001_0000_0009;
		run(8'h57, 1'b0, 1'b0, 7'h00);
		check(r[95:16], {16'h0, (projected_list[0] ^ detected_list[0]) & usable});
		run(8'h50, 1'b0, 1'b0, 7'h01);
		check(r[95:16], '0);
		apb(1'b0, 12'h0FC, '0, q);
		check({slverr, q}, {1'b1, 32'h0});
		$display("mismatch and errors done");
	endtask
	initial begin
		repeat (6) @(posedge pclk);
		check({link.req_valid, link.rsp_valid, exchange_enable_flag, id_read_only}, 6'b000011);
		presetn <= 1'b1;
		t_detected;
		t_flags;
		t_exchange;
		t_offline;
		t_other;
		close_out;
	end
endmodule
